/* smbts_pkg.sv */
// Shared constants, state codes and carriers for the bus timeout and stretch control
//
// Functional notes
// - Slave accepts 10 to 100 kHz clock
// - Master clock nominally 51.2 kHz
// - Clock low past timeout aborts transfer
// - Clock high over 50 us means idle
// - Both lines high 50 ms cancels transaction
// - Idle cancel only when stretch select cleared
// - Slave stretch at most 25 ms per message
// - Secondary fault drives fuse output
// - Master broadcasts charge current and voltage
// - Both low 2 s enters bus off
package smbts_pkg;

    // ------------------------------------------------------------
    // Clock of the system domain
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_FREQ_HZ = 1000000000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Bus timing figures and derived cycle counts
    // ------------------------------------------------------------
    // Slave clock range in kHz, the slow end coincides with idle
    localparam int SLV_FMIN_KHZ = 10;
    localparam int SLV_FMAX_KHZ = 100;
    // Shortest accepted high phase, 4 us, rounded up
    localparam int SLV_HIGH_MIN_US = 4;
    localparam logic [12:0] SLV_HIGH_MIN_CYC =
        13'((SLV_HIGH_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Master clock in tenths of kHz (51.2 kHz), half period rounded down
    localparam int MST_FREQ_KHZ_X10 = 512;
    localparam logic [9:0] MST_HALF_CYC =
        10'((CLK_FREQ_HZ * 10) / (MST_FREQ_KHZ_X10 * 2000));
    // Clock low timeout, picked inside the 25 to 35 us window
    localparam int TIMEOUT_MIN_US = 25;
    localparam int TIMEOUT_MAX_US = 35;
    localparam int TIMEOUT_US = (TIMEOUT_MIN_US + TIMEOUT_MAX_US) / 2;
    localparam logic [11:0] TIMEOUT_CYC = 12'(TIMEOUT_US * 1000 / CLK_PERIOD_NS);
    // Clock high longer than this is an idle bus
    localparam int HIGH_MAX_US = 50;
    localparam logic [12:0] HIGH_MAX_CYC = 13'(HIGH_MAX_US * 1000 / CLK_PERIOD_NS);
    // Both lines high this long resets a transaction
    localparam int IDLE_RESET_MS = 50;
    localparam logic [22:0] IDLE_RESET_CYC_DEF = 23'(IDLE_RESET_MS * (CLK_FREQ_HZ / 1000));
    // Cumulative slave stretch budget per message
    localparam int SEXT_MS = 25;
    localparam logic [21:0] SEXT_CYC_DEF = 22'(SEXT_MS * (CLK_FREQ_HZ / 1000));
    // Far master stretch budget, only the far side keeps it
    localparam int MEXT_MS = 10;
    // Both lines low this long enters bus off
    localparam int BUS_OFF_S = 2;
    localparam logic [27:0] BUS_OFF_CYC_DEF = 28'(BUS_OFF_S * CLK_FREQ_HZ);

    // ------------------------------------------------------------
    // Broadcast frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BYTES = 4;
    localparam logic [3:0] BITS_PER_SLOT = 4'h9;
    localparam logic [1:0] LAST_BYTE = 2'h3;

    // Master sequencer states
    typedef enum logic [2:0] {
        M_IDLE  = 3'b000,
        M_START = 3'b001,
        M_LOW   = 3'b010,
        M_HIGH  = 3'b011,
        M_STOPL = 3'b100,
        M_STOPH = 3'b101,
        M_STOPD = 3'b110
    } smbts_mst_state_t;

    // Charging broadcast request from the core
    typedef struct packed {
        logic isVoltage;
        logic [15:0] value;
    } smbts_req_t;

    // Two-way pin as two signals
    typedef struct packed {
        logic dout;
        logic oe;
    } smbts_pin_t;

endpackage : smbts_pkg

/* smbts_sync.sv */
// Two-flop level synchroniser, one bit per lane
`timescale 1ns/10ps
module smbts_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // First stage, read only by the second
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // Reset to each lane's idle value, so no false edge follows reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule : smbts_sync

/* smbts_ctrl.sv */
// Bus timeout, idle, stretch limit, fuse and charger broadcast control
`timescale 1ns/10ps
module smbts_ctrl #(
    parameter logic [22:0] IDLE_RESET_CYC = smbts_pkg::IDLE_RESET_CYC_DEF,
    parameter logic [21:0] SEXT_CYC = smbts_pkg::SEXT_CYC_DEF,
    parameter logic [27:0] BUS_OFF_CYC = smbts_pkg::BUS_OFF_CYC_DEF,
    parameter logic [6:0] CHARGER_ADDR = 7'h10,
    parameter logic [7:0] CMD_CURRENT = 8'h00,
    parameter logic [7:0] CMD_VOLTAGE = 8'h01
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic linkClk,
    input wire logic busClockLineIn,
    output smbts_pkg::smbts_pin_t busClockLine,
    input wire logic busDataLineIn,
    output smbts_pkg::smbts_pin_t busDataLine,
    input wire logic reqValid,
    input smbts_pkg::smbts_req_t reqData,
    output logic reqReady,
    output logic masterDone,
    output logic masterNack,
    input wire logic slaveStretchReq,
    input wire logic noClockStretchSelect,
    input wire logic secondaryFault,
    output logic fuseDrive,
    output logic transferAbort,
    output logic timeoutEvent,
    output logic slaveRateError,
    output logic busIdle,
    output logic busOff,
    output logic msgActive
);
    import smbts_pkg::*;

    // ------------------------------------------------------------
    // Link domain: pin sampling and start/stop detection
    // ------------------------------------------------------------
    logic [1:0] linkPins; // Synced clock and data on linkClk
    logic prevScl_ff, nxt_prevScl;
    logic prevSda_ff, nxt_prevSda;
    logic startTgl_ff, nxt_startTgl; // Toggles once per start
    logic stopTgl_ff, nxt_stopTgl; // Toggles once per stop

    smbts_sync #(.W(2)) uLinkSync (
        .clk(linkClk),
        .resetn(resetn),
        .d({busClockLineIn, busDataLineIn}),
        .q(linkPins)
    );

    // Start is data falling with clock high, stop is data rising
    always_comb begin
        nxt_prevScl = linkPins[1];
        nxt_prevSda = linkPins[0];
        nxt_startTgl = startTgl_ff;
        nxt_stopTgl = stopTgl_ff;
        if (prevScl_ff && linkPins[1] && prevSda_ff && !linkPins[0]) begin
            nxt_startTgl = !startTgl_ff;
        end
        if (prevScl_ff && linkPins[1] && !prevSda_ff && linkPins[0]) begin
            nxt_stopTgl = !stopTgl_ff;
        end
    end

    // Link registers only
    always_ff @(posedge linkClk or negedge resetn) begin
        if (!resetn) begin
            prevScl_ff <= 1'b1;
            prevSda_ff <= 1'b1;
            startTgl_ff <= 1'b0;
            stopTgl_ff <= 1'b0;
        end else begin
            prevScl_ff <= nxt_prevScl;
            prevSda_ff <= nxt_prevSda;
            startTgl_ff <= nxt_startTgl;
            stopTgl_ff <= nxt_stopTgl;
        end
    end

    // ------------------------------------------------------------
    // Crossing into the system domain
    // ------------------------------------------------------------
    logic [3:0] sysIn; // Levels and toggles after two flops
    logic sclS; // Clock line level, system domain
    logic sdaS; // Data line level, system domain
    logic startEvt; // One-cycle start seen
    logic stopEvt; // One-cycle stop seen

    // Toggles are single bits, so lane skew cannot split an event
    // Levels reset high and toggles low, as the link registers do
    smbts_sync #(.W(4), .RST_VAL(4'hc)) uSysSync (
        .clk(clk),
        .resetn(resetn),
        .d({linkPins, startTgl_ff, stopTgl_ff}),
        .q(sysIn)
    );

    // ------------------------------------------------------------
    // Bus timers, message tracking, fuse and bus off
    // ------------------------------------------------------------
    logic startSeen_ff, nxt_startSeen;
    logic stopSeen_ff, nxt_stopSeen;
    logic [11:0] lowCnt_ff, nxt_lowCnt; // Current clock-low length
    logic [12:0] highCnt_ff, nxt_highCnt; // Current clock-high length
    logic [22:0] idleCnt_ff, nxt_idleCnt; // Both lines high
    logic [27:0] offCnt_ff, nxt_offCnt; // Both lines low
    logic [21:0] stretchCnt_ff, nxt_stretchCnt; // Own stretch in this message
    logic timeoutPulse_ff, nxt_timeoutPulse;
    logic idleResetPulse_ff, nxt_idleResetPulse;
    logic rateErr_ff, nxt_rateErr;
    logic busIdle_ff, nxt_busIdle;
    logic busOff_ff, nxt_busOff;
    logic msgActive_ff, nxt_msgActive;
    logic fuse_ff, nxt_fuse;
    logic sclPrev_ff, nxt_sclPrev;
    logic timeoutHit; // Timeout reached this cycle
    logic idleHit; // Idle reset reached this cycle
    logic stretchActive; // Device holds clock low as slave
    smbts_mst_state_t mstState_ff, nxt_mstState;

    assign sclS = sysIn[3];
    assign sdaS = sysIn[2];
    assign startEvt = sysIn[1] != startSeen_ff;
    assign stopEvt = sysIn[0] != stopSeen_ff;

    assign timeoutHit = !sclS && (lowCnt_ff == TIMEOUT_CYC - 12'h001);
    // idle-high cancel, gated by stretch select
    assign idleHit = sclS && sdaS && !noClockStretchSelect &&
                     (idleCnt_ff == IDLE_RESET_CYC - 23'h000001);
    // stretch only within budget and never past a timeout
    assign stretchActive = slaveStretchReq && msgActive_ff && (mstState_ff == M_IDLE) &&
                           (stretchCnt_ff < SEXT_CYC) && (lowCnt_ff != TIMEOUT_CYC);

    // Next values of timers and flags
    always_comb begin
        nxt_startSeen = sysIn[1];
        nxt_stopSeen = sysIn[0];
        nxt_sclPrev = sclS;
        nxt_lowCnt = 12'h000;
        nxt_highCnt = 13'h0000;
        nxt_idleCnt = 23'h000000;
        nxt_offCnt = 28'h0000000;
        nxt_stretchCnt = stretchCnt_ff;
        nxt_timeoutPulse = timeoutHit;
        nxt_idleResetPulse = idleHit;
        nxt_rateErr = 1'b0;
        nxt_busIdle = busIdle_ff;
        nxt_busOff = busOff_ff;
        nxt_msgActive = msgActive_ff;
        // fuse drive latches on and stays
        nxt_fuse = fuse_ff || secondaryFault;
        // Low timer saturates so one low phase gives one timeout
        if (!sclS) begin
            nxt_lowCnt = (lowCnt_ff == TIMEOUT_CYC) ? lowCnt_ff : lowCnt_ff + 12'h001;
        end
        if (sclS) begin
            nxt_highCnt = (highCnt_ff == HIGH_MAX_CYC) ? highCnt_ff : highCnt_ff + 13'h0001;
        end
        // high phase too short for a 100 kHz bus
        if (sclPrev_ff && !sclS && (highCnt_ff < SLV_HIGH_MIN_CYC)) begin
            nxt_rateErr = 1'b1;
        end
        if (!sclS || startEvt) begin
            nxt_busIdle = 1'b0;
        end else if (highCnt_ff == HIGH_MAX_CYC - 13'h0001) begin
            nxt_busIdle = 1'b1;
        end
        if (sclS && sdaS) begin
            nxt_idleCnt = (idleCnt_ff == IDLE_RESET_CYC) ? idleCnt_ff : idleCnt_ff + 23'h000001;
        end
        // both low enters bus off, either high leaves it
        if (!sclS && !sdaS) begin
            nxt_offCnt = (offCnt_ff == BUS_OFF_CYC) ? offCnt_ff : offCnt_ff + 28'h0000001;
            if (offCnt_ff == BUS_OFF_CYC - 28'h0000001) begin
                nxt_busOff = 1'b1;
            end
        end else begin
            nxt_busOff = 1'b0;
        end
        // budget counts from the first start of a message
        if (startEvt && !msgActive_ff) begin
            nxt_stretchCnt = 22'h000000;
        end else if (stretchActive) begin
            nxt_stretchCnt = stretchCnt_ff + 22'h000001;
        end
        // Start wins over a stop or abort in the same cycle
        if (startEvt) begin
            nxt_msgActive = 1'b1;
        end else if (stopEvt || timeoutHit || idleHit) begin
            nxt_msgActive = 1'b0;
        end
    end

    // Timer registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            startSeen_ff <= 1'b0;
            stopSeen_ff <= 1'b0;
            sclPrev_ff <= 1'b1;
            lowCnt_ff <= 12'h000;
            highCnt_ff <= 13'h0000;
            idleCnt_ff <= 23'h000000;
            offCnt_ff <= 28'h0000000;
            stretchCnt_ff <= 22'h000000;
            timeoutPulse_ff <= 1'b0;
            idleResetPulse_ff <= 1'b0;
            rateErr_ff <= 1'b0;
            busIdle_ff <= 1'b0;
            busOff_ff <= 1'b0;
            msgActive_ff <= 1'b0;
            fuse_ff <= 1'b0;
        end else begin
            startSeen_ff <= nxt_startSeen;
            stopSeen_ff <= nxt_stopSeen;
            sclPrev_ff <= nxt_sclPrev;
            lowCnt_ff <= nxt_lowCnt;
            highCnt_ff <= nxt_highCnt;
            idleCnt_ff <= nxt_idleCnt;
            offCnt_ff <= nxt_offCnt;
            stretchCnt_ff <= nxt_stretchCnt;
            timeoutPulse_ff <= nxt_timeoutPulse;
            idleResetPulse_ff <= nxt_idleResetPulse;
            rateErr_ff <= nxt_rateErr;
            busIdle_ff <= nxt_busIdle;
            busOff_ff <= nxt_busOff;
            msgActive_ff <= nxt_msgActive;
            fuse_ff <= nxt_fuse;
        end
    end

    // ------------------------------------------------------------
    // Master broadcast sequencer
    // ------------------------------------------------------------
    logic [9:0] divCnt_ff, nxt_divCnt; // Half-period divider
    logic [35:0] frame_ff, nxt_frame; // Bytes with released ack slots
    logic [3:0] bitInByte_ff, nxt_bitInByte;
    logic [1:0] byteCnt_ff, nxt_byteCnt;
    logic done_ff, nxt_done;
    logic nack_ff, nxt_nack;
    logic halfDone; // Divider reached a half period
    logic [7:0] cmdSel; // Command byte for this request

    assign halfDone = divCnt_ff == MST_HALF_CYC - 10'h001;
    assign cmdSel = reqData.isVoltage ? CMD_VOLTAGE : CMD_CURRENT;
    // Start only on a quiet, usable bus
    assign reqReady = (mstState_ff == M_IDLE) && busIdle_ff && !busOff_ff && !msgActive_ff;

    // Next state of the broadcast sequencer
    always_comb begin
        nxt_mstState = mstState_ff;
        nxt_divCnt = halfDone ? 10'h000 : divCnt_ff + 10'h001;
        nxt_frame = frame_ff;
        nxt_bitInByte = bitInByte_ff;
        nxt_byteCnt = byteCnt_ff;
        nxt_done = 1'b0;
        nxt_nack = nack_ff;
        case (mstState_ff)
            M_IDLE: begin
                nxt_divCnt = 10'h000;
                // word write of charge current or voltage
                if (reqValid && reqReady) begin
                    nxt_frame = {CHARGER_ADDR, 1'b0, 1'b1, cmdSel, 1'b1,
                                 reqData.value[7:0], 1'b1, reqData.value[15:8], 1'b1};
                    nxt_bitInByte = 4'h0;
                    nxt_byteCnt = 2'h0;
                    nxt_nack = 1'b0;
                    nxt_mstState = M_START;
                end
            end
            M_START: begin
                if (halfDone) begin
                    nxt_mstState = M_LOW;
                end
            end
            M_LOW: begin
                if (halfDone) begin
                    nxt_mstState = M_HIGH;
                end
            end
            M_HIGH: begin
                // a stretching slave holds the divider
                if (!sclS) begin
                    nxt_divCnt = 10'h000;
                end else if (halfDone) begin
                    nxt_frame = {frame_ff[34:0], 1'b1};
                    if (bitInByte_ff == BITS_PER_SLOT - 4'h1) begin
                        nxt_nack = nack_ff || sdaS;
                        nxt_bitInByte = 4'h0;
                        nxt_byteCnt = byteCnt_ff + 2'h1;
                        nxt_mstState = (byteCnt_ff == LAST_BYTE || sdaS) ? M_STOPL : M_LOW;
                    end else begin
                        nxt_bitInByte = bitInByte_ff + 4'h1;
                        nxt_mstState = M_LOW;
                    end
                end
            end
            M_STOPL: begin
                if (halfDone) begin
                    nxt_mstState = M_STOPH;
                end
            end
            M_STOPH: begin
                if (!sclS) begin
                    nxt_divCnt = 10'h000;
                end else if (halfDone) begin
                    nxt_mstState = M_STOPD;
                end
            end
            M_STOPD: begin
                if (halfDone) begin
                    nxt_done = 1'b1;
                    nxt_mstState = M_IDLE;
                end
            end
            default: begin
                nxt_mstState = M_IDLE;
            end
        endcase
        // abandon the frame and release both lines
        if (timeoutHit || idleHit) begin
            nxt_mstState = M_IDLE;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mstState_ff <= M_IDLE;
            divCnt_ff <= 10'h000;
            frame_ff <= '1;
            bitInByte_ff <= 4'h0;
            byteCnt_ff <= 2'h0;
            done_ff <= 1'b0;
            nack_ff <= 1'b0;
        end else begin
            mstState_ff <= nxt_mstState;
            divCnt_ff <= nxt_divCnt;
            frame_ff <= nxt_frame;
            bitInByte_ff <= nxt_bitInByte;
            byteCnt_ff <= nxt_byteCnt;
            done_ff <= nxt_done;
            nack_ff <= nxt_nack;
        end
    end

    // ------------------------------------------------------------
    // Pin drive and outputs
    // ------------------------------------------------------------
    // Lines are only ever pulled low; the pull-up makes the high
    assign busClockLine.dout = 1'b0;
    assign busDataLine.dout = 1'b0;
    assign busClockLine.oe = stretchActive || (mstState_ff == M_LOW) || (mstState_ff == M_STOPL);
    assign busDataLine.oe = (mstState_ff == M_START) || (mstState_ff == M_STOPL) ||
                            (mstState_ff == M_STOPH) ||
                            (((mstState_ff == M_LOW) || (mstState_ff == M_HIGH)) && !frame_ff[35]);
    assign masterDone = done_ff;
    assign masterNack = nack_ff;
    assign fuseDrive = fuse_ff;
    assign transferAbort = timeoutPulse_ff || idleResetPulse_ff;
    assign timeoutEvent = timeoutPulse_ff;
    assign slaveRateError = rateErr_ff;
    assign busIdle = busIdle_ff;
    assign busOff = busOff_ff;
    assign msgActive = msgActive_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    timeout_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
        !sclS && lowCnt_ff == TIMEOUT_CYC - 12'h001 |=> timeoutPulse_ff)
        else $error("clock low timeout not flagged");
    timeout_release_a: assert property (@(posedge clk) disable iff (!resetn)
        timeoutPulse_ff |-> !busClockLine.oe && mstState_ff == M_IDLE)
        else $error("lines still driven after timeout");
    idle_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        sclS && !startEvt && highCnt_ff == HIGH_MAX_CYC - 13'h0001 |=> busIdle_ff)
        else $error("idle not flagged after long high");
    idle_reset_a: assert property (@(posedge clk) disable iff (!resetn)
        sclS && sdaS && !noClockStretchSelect && idleCnt_ff == IDLE_RESET_CYC - 23'h000001
        |=> idleResetPulse_ff && !msgActive_ff)
        else $error("idle-high cancel missing");
    idle_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        idleResetPulse_ff |-> !$past(noClockStretchSelect))
        else $error("idle cancel while stretch select set");
    stretch_budget_a: assert property (@(posedge clk) disable iff (!resetn)
        stretchCnt_ff >= SEXT_CYC && mstState_ff == M_IDLE |-> !busClockLine.oe)
        else $error("stretch past cumulative budget");
    fuse_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        secondaryFault |=> fuseDrive ##1 fuseDrive)
        else $error("fuse drive not held");
    master_half_a: assert property (@(posedge clk) disable iff (!resetn)
        mstState_ff == M_LOW && halfDone && !timeoutHit && !idleHit |=> mstState_ff == M_HIGH)
        else $error("master low half wrong length");
    bus_off_exit_a: assert property (@(posedge clk) disable iff (!resetn)
        busOff_ff && (sclS || sdaS) |=> !busOff_ff)
        else $error("bus off not left");
    rate_err_a: assert property (@(posedge clk) disable iff (!resetn)
        sclPrev_ff && !sclS && highCnt_ff < SLV_HIGH_MIN_CYC |=> slaveRateError)
        else $error("short high not flagged");

    done_c: cover property (@(posedge clk) disable iff (!resetn) masterDone && !masterNack);
    timeout_c: cover property (@(posedge clk) disable iff (!resetn) timeoutEvent);
    bus_off_c: cover property (@(posedge clk) disable iff (!resetn) $rose(busOff_ff));
    stretch_c: cover property (@(posedge clk) disable iff (!resetn) stretchActive ##1 !stretchActive);

endmodule : smbts_ctrl

/* smbts_far.sv */
// Far-side bus party model with pulled-up wires
`timescale 1ns/10ps
module smbts_far (
    input wire logic clkOe,
    input wire logic datOe,
    input wire logic farClkLow,
    input wire logic farDatLow,
    output logic clkLine,
    output logic datLine
);
    // far stretch kept short
    // Pull-ups: a released wire reads high
    assign clkLine = !(clkOe || farClkLow);
    assign datLine = !(datOe || farDatLow);
endmodule : smbts_far

/* testbench.sv */
// Self-checking bench for the bus timeout and stretch control
`timescale 1ns/10ps
module testbench;
    import smbts_pkg::*;
    logic clk = 1'b0;
    logic linkClk = 1'b0;
    logic resetn = 1'b0;
    logic fc = 1'b0;
    logic fd = 1'b0;
    logic reqValid = 1'b0;
    smbts_req_t reqData = '0;
    logic ncs = 1'b0;
    logic sf = 1'b0;
    logic ss = 1'b0;
    logic pc;
    logic [7:0] sh;
    // Charger address given to the design, arbitrary
    localparam logic [6:0] ADDR = 7'h10;
    smbts_pin_t cp, dp;
    logic cl, dl, rr, md, mn, fz, ta, te, se, bi, bo, ma;
    int bad_count = 0;
    int n_tests = 0;
    int a, t, i, r, k;
    always #5 clk = ~clk;
    // Phase offset keeps link edges unrelated
    initial #7 forever #15 linkClk = ~linkClk;
    smbts_far i_smbts_far (.clkOe(cp.oe), .datOe(dp.oe), .farClkLow(fc),
        .farDatLow(fd), .clkLine(cl), .datLine(dl));
    smbts_ctrl #(.IDLE_RESET_CYC(23'h0000c8), .SEXT_CYC(22'h00012c),
        .BUS_OFF_CYC(28'h00001f4), .CHARGER_ADDR(ADDR))
        i_smbts_ctrl (.clk(clk), .resetn(resetn),
        .linkClk(linkClk), .busClockLineIn(cl), .busClockLine(cp), .busDataLineIn(dl),
        .busDataLine(dp), .reqValid(reqValid), .reqData(reqData), .reqReady(rr),
        .masterDone(md), .masterNack(mn), .slaveStretchReq(ss),
        .noClockStretchSelect(ncs), .secondaryFault(sf), .fuseDrive(fz),
        .transferAbort(ta), .timeoutEvent(te), .slaveRateError(se), .busIdle(bi),
        .busOff(bo), .msgActive(ma));
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    task automatic chk(input string w, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %b seen %b", w, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic chkB(input string w, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", w, e, g);
            bad_count++;
        end
    endtask : chkB
    // Bounded wait ran out
    task automatic bound(input logic ok, input string w);
        if (!ok) begin
            chk(w, 1'b1, 1'b0);
            results();
        end
    endtask : bound
    // Drive and sample just after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic cnt(input int n);
        a = 0;
        t = 0;
        r = 0;
        repeat (n) begin
            step(1);
            a += int'(ta === 1'b1);
            t += int'(te === 1'b1);
            r += int'(se === 1'b1);
        end
    endtask : cnt
    task automatic waitIdle;
        for (i = 0; i < 7000 && rr !== 1'b1; i++) step(1);
        bound(rr === 1'b1, "reqReady");
    endtask : waitIdle
    task automatic tIdle;
        step(4000);
        chk("busIdle early", 1'b0, bi);
        waitIdle();
        chk("busIdle", 1'b1, bi);
        $display("idle test done");
    endtask : tIdle
    task automatic tFuse;
        chk("fuse off", 1'b0, fz);
        sf = 1'b1;
        step(3);
        sf = 1'b0;
        step(3);
        chk("fuse sticky", 1'b1, fz);
        $display("fuse test done");
    endtask : tFuse
    // Far side opens a message, then the device holds the clock low
    task automatic tStretch;
        fd = 1'b1;
        step(10);
        fc = 1'b1;
        step(10);
        chk("msgActive", 1'b1, ma);
        fd = 1'b0;
        ss = 1'b1;
        step(10);
        fc = 1'b0;
        step(200);
        chk("stretch held", 1'b0, cl);
        step(150);
        chk("stretch budget", 1'b1, cl);
        ss = 1'b0;
        $display("stretch test done");
    endtask : tStretch
    task automatic tTimeout;
        fc = 1'b1;
        cnt(2400);
        chk("timeout early", 1'b0, t > 0);
        chk("rate error", 1'b1, r == 1);
        cnt(1200);
        chk("timeout", 1'b1, t == 1);
        chk("abort", 1'b1, a == 1);
        fc = 1'b0;
        $display("timeout test done");
    endtask : tTimeout
    task automatic tBusOff;
        step(20);
        fc = 1'b1;
        fd = 1'b1;
        cnt(400);
        chk("busOff early", 1'b0, bo);
        cnt(300);
        chk("busOff", 1'b1, bo);
        fd = 1'b0;
        step(20);
        chk("busOff leave", 1'b0, bo);
        fc = 1'b0;
        $display("bus off test done");
    endtask : tBusOff
    // A short data pulse under a high clock leaves both-high
    task automatic tCancel(input logic sel);
        ncs = sel;
        fd = 1'b1;
        step(10);
        fd = 1'b0;
        cnt(400);
        chk("idle cancel", !sel, a > 0);
        $display("idle cancel test done");
    endtask : tCancel
    task automatic tMaster;
        // Scaled idle cancel is shorter than one bit, so keep it off here
        ncs = 1'b1;
        waitIdle();
        reqData = '{1'b1, 16'h1234};
        reqValid = 1'b1;
        step(1);
        reqValid = 1'b0;
        for (i = 0; i < 3000 && cl !== 1'b0; i++) step(1);
        bound(cl === 1'b0, "clock low");
        for (i = 0; i < 2000 && cl !== 1'b1; i++) step(1);
        chk("half period", 1'b1, i >= 966 && i <= 986);
        // Data sampled at the first eight clock rises, first rise already seen
        sh = {7'h00, dl};
        k = 1;
        for (i = 0; i < 40000 && md !== 1'b1; i++) begin
            pc = cl;
            step(1);
            if (cl === 1'b1 && pc === 1'b0 && k < 8) begin
                sh = {sh[6:0], dl};
                k++;
            end
        end
        bound(md === 1'b1, "masterDone");
        chkB("address byte", {ADDR, 1'b0}, sh);
        chk("no ack seen", 1'b1, mn);
        $display("master test done");
    endtask : tMaster
    initial begin
        step(8);
        resetn = 1'b1;
        tIdle();
        tFuse();
        tStretch();
        tTimeout();
        tBusOff();
        tCancel(1'b1);
        tCancel(1'b0);
        tMaster();
        results();
    end
endmodule : testbench
